/* File: tslld_pkg.sv */
// constants, types and register map of the descriptor dma channel control
//
// Notes on behaviour
// R1: descriptor queue holds 64 entries per channel
// R2: threshold field picks irq fraction of depth
// R3: burst select gives 4, 8, 16 beats
// R4: trigger bit picks hardware or software launch
// R5: fixed address bit holds address across beats
// R6: software sets config done after descriptors ready
// R7: hardware clears config done when list finishes
// R8: pause finishes current burst then halts
// R9: clearing pause resumes from the halt point
// R10: stop finishes current burst then stops channel
// R11: start launches channel, clears itself next cycle
// R12: base address register, full 32 bits
// R13: software write counter, eight bits, rest zero
// R14: hardware read counter, eight bits, resets zero
// R15: low done register: filters 0 to 31
// R16: high done register: filters 32 to 63
// R17: source select low feeds stream from dma
// R18: run while read and write counters differ
`default_nettype none
package tslld_pkg;

  localparam logic [11:0] OFS_CFG     = 12'h104;
  localparam logic [11:0] OFS_BASE    = 12'h108;
  localparam logic [11:0] OFS_SWCNT   = 12'h10c;
  localparam logic [11:0] OFS_HWCNT   = 12'h110;
  localparam logic [11:0] OFS_DONE_LO = 12'h114;
  localparam logic [11:0] OFS_DONE_HI = 12'h118;

  localparam int CFG_START = 0;
  localparam int CFG_STOP  = 1;
  localparam int CFG_PAUSE = 2;
  localparam int CFG_DONE  = 3;
  localparam int CFG_FIXED = 4;
  localparam int CFG_TRIG  = 5;
  localparam int CFG_BURST = 6;
  localparam int CFG_THR   = 8;

  localparam int QUEUE_DEPTH = 64;
  localparam int SLOT_W      = 6;
  localparam int CNT_W       = 8;
  localparam int NUM_FILTERS = 64;
  localparam int HALF_FLAGS  = 32;

  localparam logic [SLOT_W-1:0] SLOT_MASK  = 6'h3f;
  localparam logic [1:0]        BURST_I4   = 2'h0;
  localparam logic [1:0]        BURST_I8   = 2'h1;
  localparam logic [1:0]        BURST_I16  = 2'h2;
  localparam logic [4:0]        BEATS_4    = 5'h04;
  localparam logic [4:0]        BEATS_8    = 5'h08;
  localparam logic [4:0]        BEATS_16   = 5'h10;
  localparam logic [4:0]        DESC_BEATS = 5'h02;
  localparam int                DESC_SHIFT = 3;
  localparam logic [31:0]       WORD_BYTES = 32'h4;

  typedef enum logic [2:0] {
    S_NEXT,
    S_DESC_REQ,
    S_DESC_DATA,
    S_XFER_REQ,
    S_XFER_DATA
  } tslld_state_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [4:0]  beats;
    logic        fixed;
  } tslld_mem_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } tslld_ts_word_t;

endpackage
`default_nettype wire

/* File: tslld_done_flags.sv */
// per-filter sticky done flags with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module tslld_done_flags
  import tslld_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_core_n,
  input  wire logic                   soft_clear,
  input  wire logic [NUM_FILTERS-1:0] filter_channel_finished,
  input  wire logic                   clr_lo_en,
  input  wire logic                   clr_hi_en,
  input  wire logic [31:0]            clr_data,
  output logic      [NUM_FILTERS-1:0] flags
);

  typedef struct packed {
    logic [NUM_FILTERS-1:0] done;
  } tslld_flag_st_t;

  tslld_flag_st_t         flag_reg;
  tslld_flag_st_t         flag_next;
  logic [NUM_FILTERS-1:0] bit_next;

  ////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILTERS; gi++)
    begin : g_flag
      logic clr;
      if (gi < HALF_FLAGS)
      begin : g_lo
        assign clr = clr_lo_en & clr_data[gi]; // R15
      end
      else
      begin : g_hi
        assign clr = clr_hi_en & clr_data[gi-HALF_FLAGS]; // R16
      end
      // a finish arriving with the clear write is kept
      assign bit_next[gi] = filter_channel_finished[gi] |
                            (flag_reg.done[gi] & ~clr);
    end
  endgenerate

  always_comb
  begin
    flag_next      = flag_reg;
    flag_next.done = soft_clear ? '0 : bit_next;
  end

  always_ff @(posedge clk_sys or negedge rst_core_n)
  begin
    if (!rst_core_n)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  assign flags = flag_reg.done;

endmodule // tslld_done_flags
`default_nettype wire

/* File: tslld_dma_ctrl.sv */
// linked-list descriptor dma channel with register port and done status
`timescale 1ns/1ps
`default_nettype none
module tslld_dma_ctrl
  import tslld_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   soft_clear,
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  input  wire logic [11:0]            reg_addr,
  input  wire logic [31:0]            reg_wdata,
  output logic      [31:0]            reg_rdata,
  output logic                        reg_rd_valid,
  output tslld_mem_cmd_t              mem_cmd,
  input  wire logic                   mem_gnt,
  input  wire logic                   mem_rvalid,
  input  wire logic [31:0]            mem_rdata,
  input  wire logic                   trig_pulse_in,
  input  wire logic                   xfer_int_en,
  input  wire logic                   stream_src_ext,
  input  wire tslld_ts_word_t         ext_ts,
  output tslld_ts_word_t              ts_out,
  output logic                        thresh_irq,
  output logic                        xfer_done,
  output logic                        dma_paused,
  input  wire logic [NUM_FILTERS-1:0] filter_channel_finished
);

  typedef struct packed {
    tslld_state_t   state;
    logic [31:0]    base;
    logic [CNT_W-1:0] sw_cnt;
    logic [CNT_W-1:0] hw_cnt;
    logic [1:0]     thr;
    logic [1:0]     burst;
    logic           trig;
    logic           fixed;
    logic           cfg_done;
    logic           pause;
    logic           stop;
    logic           start;
    logic           active;
    logic           in_desc;
    logic [31:0]    cur_addr;
    logic [31:0]    remain;
    logic [4:0]     beat_cnt;
    tslld_mem_cmd_t mem;
    tslld_ts_word_t ts;
    logic           irq;
    logic           done;
    logic           paused;
    logic [31:0]    rdata;
    logic           rd_valid;
  } tslld_core_st_t;

  logic [1:0]             rst_sync_reg;
  logic                   rst_core_n;
  tslld_core_st_t         core_reg;
  tslld_core_st_t         core_next;
  logic [NUM_FILTERS-1:0] done_flags;
  logic                   clr_lo_en;
  logic                   clr_hi_en;
  logic [4:0]             burst_beats;
  logic                   launch;
  logic [SLOT_W-1:0]      slot_next;
  logic [SLOT_W-1:0]      thr_mask;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_core_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  assign clr_lo_en = reg_wr_en & (reg_addr == OFS_DONE_LO);
  assign clr_hi_en = reg_wr_en & (reg_addr == OFS_DONE_HI);

  tslld_done_flags i_tslld_done_flags (
    .clk_sys                 (clk_sys),
    .rst_core_n              (rst_core_n),
    .soft_clear              (soft_clear),
    .filter_channel_finished (filter_channel_finished),
    .clr_lo_en               (clr_lo_en),
    .clr_hi_en               (clr_hi_en),
    .clr_data                (reg_wdata),
    .flags                   (done_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // reserved burst code falls back to the shortest burst
  always_comb
  begin
    unique case (core_reg.burst)
      BURST_I8:  burst_beats = BEATS_8;  // R3
      BURST_I16: burst_beats = BEATS_16; // R3
      default:   burst_beats = BEATS_4;  // R3
    endcase
  end

  // software start lives one cycle, so a software launch is a single pulse; a hardware launch follows trig_pulse_in
  assign launch = core_reg.trig ? trig_pulse_in : core_reg.start; // R4
  assign slot_next = core_reg.hw_cnt[SLOT_W-1:0] + 6'h01; // R1
  assign thr_mask  = SLOT_MASK >> core_reg.thr; // R2

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    core_next          = core_reg;
    core_next.start    = 1'b0; // R11
    core_next.irq      = 1'b0;
    core_next.done     = 1'b0;
    core_next.ts.valid = 1'b0;
    core_next.rd_valid = reg_rd_en;
    core_next.rdata    = 32'h0;

    // register writes
    if (reg_wr_en)
    begin
      unique case (reg_addr)
        OFS_CFG:
        begin
          core_next.thr   = reg_wdata[CFG_THR +: 2];
          core_next.burst = reg_wdata[CFG_BURST +: 2];
          core_next.trig  = reg_wdata[CFG_TRIG];
          core_next.fixed = reg_wdata[CFG_FIXED];
          core_next.pause = reg_wdata[CFG_PAUSE]; // R8 R9
          if (reg_wdata[CFG_START])
            core_next.start = 1'b1; // R11
          if (reg_wdata[CFG_STOP])
            core_next.stop = 1'b1; // R10
        end
        OFS_BASE:  core_next.base   = reg_wdata; // R12
        OFS_SWCNT: core_next.sw_cnt = reg_wdata[CNT_W-1:0]; // R13
        default:   ;
      endcase
    end

    if (launch)
      core_next.active = 1'b1;

    // channel sequencer; control decisions only at burst boundaries
    unique case (core_reg.state)
      S_NEXT:
      begin
        if (!core_reg.active)
        begin
          if (!launch)
            core_next.stop = 1'b0;
        end
        else if (core_reg.stop)
        begin
          core_next.active   = 1'b0; // R10
          core_next.stop     = 1'b0;
          core_next.in_desc  = 1'b0;
          core_next.cfg_done = 1'b0;
          core_next.done     = 1'b1;
        end
        else if (core_reg.pause)
        begin
          core_next.active = 1'b1; // R8
        end
        else if (core_reg.in_desc && core_reg.remain != 32'h0)
        begin
          core_next.mem.req   = 1'b1; // R9
          core_next.mem.addr  = core_reg.cur_addr;
          core_next.mem.fixed = core_reg.fixed; // R5
          core_next.mem.beats = (core_reg.remain < 32'(burst_beats)) ?
                                core_reg.remain[4:0] : burst_beats; // R3
          core_next.state     = S_XFER_REQ;
        end
        else if (core_reg.in_desc)
        begin
          core_next.in_desc = 1'b0;
          core_next.hw_cnt  = core_reg.hw_cnt + 8'h01; // R14
          if (((slot_next & thr_mask) == 6'h00) && xfer_int_en)
            core_next.irq = 1'b1; // R2
        end
        else if (core_reg.hw_cnt != core_reg.sw_cnt)
        begin
          core_next.mem.req   = 1'b1; // R18
          core_next.mem.addr  = core_reg.base +
            (32'(core_reg.hw_cnt[SLOT_W-1:0]) << DESC_SHIFT); // R1
          core_next.mem.fixed = 1'b0;
          core_next.mem.beats = DESC_BEATS;
          core_next.state     = S_DESC_REQ;
        end
        else
        begin
          core_next.active   = 1'b0; // R18
          core_next.cfg_done = 1'b0; // R7
          core_next.done     = 1'b1;
        end
      end
      S_DESC_REQ, S_XFER_REQ:
      begin
        if (mem_gnt)
        begin
          core_next.mem.req  = 1'b0;
          core_next.beat_cnt = 5'h00;
          core_next.state    = (core_reg.state == S_DESC_REQ) ?
                               S_DESC_DATA : S_XFER_DATA;
        end
      end
      S_DESC_DATA:
      begin
        if (mem_rvalid)
        begin
          core_next.beat_cnt = core_reg.beat_cnt + 5'h01;
          if (core_reg.beat_cnt == 5'h00)
            core_next.cur_addr = mem_rdata;
          else
          begin
            core_next.remain  = mem_rdata;
            core_next.in_desc = 1'b1;
            core_next.state   = S_NEXT;
          end
        end
      end
      S_XFER_DATA:
      begin
        if (mem_rvalid)
        begin
          core_next.beat_cnt = core_reg.beat_cnt + 5'h01;
          core_next.remain   = core_reg.remain - 32'h1;
          if (!core_reg.fixed)
            core_next.cur_addr = core_reg.cur_addr + WORD_BYTES; // R5
          if (!stream_src_ext)
          begin
            core_next.ts.valid = 1'b1; // R17
            core_next.ts.data  = mem_rdata;
          end
          if (core_reg.beat_cnt == core_reg.mem.beats - 5'h01)
            core_next.state = S_NEXT;
        end
      end
      default: core_next.state = S_NEXT;
    endcase

    // external stream passes through when it is the chosen source
    if (stream_src_ext)
      core_next.ts = ext_ts; // R17

    // software set of config done beats a same-cycle hardware clear
    if (reg_wr_en && reg_addr == OFS_CFG && reg_wdata[CFG_DONE])
      core_next.cfg_done = 1'b1; // R6

    core_next.paused = core_next.active && core_next.pause &&
                       core_next.state == S_NEXT; // R8

    // register reads, one cycle latency
    if (reg_rd_en)
    begin
      unique case (reg_addr)
        OFS_CFG:
        begin
          core_next.rdata[CFG_THR +: 2]   = core_reg.thr;
          core_next.rdata[CFG_BURST +: 2] = core_reg.burst;
          core_next.rdata[CFG_TRIG]       = core_reg.trig;
          core_next.rdata[CFG_FIXED]      = core_reg.fixed;
          core_next.rdata[CFG_DONE]       = core_reg.cfg_done;
          core_next.rdata[CFG_PAUSE]      = core_reg.pause;
          core_next.rdata[CFG_STOP]       = core_reg.stop;
          core_next.rdata[CFG_START]      = core_reg.start;
        end
        OFS_BASE:    core_next.rdata = core_reg.base;
        OFS_SWCNT:   core_next.rdata = {24'h0, core_reg.sw_cnt}; // R13
        OFS_HWCNT:   core_next.rdata = {24'h0, core_reg.hw_cnt}; // R14
        OFS_DONE_LO: core_next.rdata = done_flags[HALF_FLAGS-1:0]; // R15
        OFS_DONE_HI:
          core_next.rdata = done_flags[NUM_FILTERS-1:HALF_FLAGS]; // R16
        default:     core_next.rdata = 32'h0;
      endcase
    end

    // soft clear wipes the channel but still answers a read
    if (soft_clear)
    begin
      core_next          = '0;
      core_next.rd_valid = reg_rd_en;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_core_n)
  begin
    if (!rst_core_n)
      core_reg <= '0;
    else
      core_reg <= core_next;
  end

  ////////////////////////////////////////////////////////////////////////
  assign reg_rdata    = core_reg.rdata;
  assign reg_rd_valid = core_reg.rd_valid;
  assign mem_cmd      = core_reg.mem;
  assign ts_out       = core_reg.ts;
  assign thresh_irq   = core_reg.irq;
  assign xfer_done    = core_reg.done;
  assign dma_paused   = core_reg.paused;

endmodule // tslld_dma_ctrl
`default_nettype wire

/* File: tslld_mem_model.sv */
// behavioural system memory answering the descriptor dma master
`timescale 1ns/1ps
`default_nettype none
module tslld_mem_model
  import tslld_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           slow,
  input  wire tslld_mem_cmd_t mem_cmd,
  output logic                mem_gnt,
  output logic                mem_rvalid,
  output logic [31:0]         mem_rdata
);
  logic [31:0] a;
  logic [4:0]  n;
  logic        f;
  ////////////////////////////////////////////////////////////
  // below 0x1000 sit descriptors: data address, then 5 words
  function automatic logic [31:0] word(input logic [31:0] x);
    if (x < 32'h1000)
      return x[2] ? 32'h5 : (32'h1000 | {x[8:3], 8'h00});
    return x ^ 32'ha5a5_0000;
  endfunction
  initial
  begin
    mem_gnt = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata = 32'h0;
    forever
    begin
      @(posedge clk_sys);
      if (mem_cmd.req)
      begin
        repeat (slow ? 3 : 0) @(posedge clk_sys);
        a = mem_cmd.addr;
        n = mem_cmd.beats;
        f = mem_cmd.fixed;
        mem_gnt <= 1'b1;
        @(posedge clk_sys);
        mem_gnt <= 1'b0;
        repeat (n)
        begin
          mem_rvalid <= 1'b1;
          mem_rdata  <= word(a);
          a = f ? a : a + WORD_BYTES;
          @(posedge clk_sys);
        end
        mem_rvalid <= 1'b0;
        // released bus shows no stale word
        mem_rdata  <= ~word(a);
      end
    end
  end
endmodule // tslld_mem_model
`default_nettype wire

/* File: tslld_dma_ctrl_chk.sv */
// port assertions of the descriptor dma channel
`timescale 1ns/1ps
`default_nettype none
module tslld_dma_ctrl_chk
  import tslld_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           rst_n,
  input wire logic           reg_rd_en,
  input wire logic [11:0]    reg_addr,
  input wire logic [31:0]    reg_rdata,
  input wire logic           reg_rd_valid,
  input wire tslld_mem_cmd_t mem_cmd,
  input wire logic           mem_gnt,
  input wire logic           mem_rvalid,
  input wire logic           xfer_int_en,
  input wire logic           stream_src_ext,
  input wire tslld_ts_word_t ts_out,
  input wire logic           thresh_irq,
  input wire logic           xfer_done,
  input wire logic           dma_paused
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  AST_RD_LAT: assert property (##1 reg_rd_valid == $past(reg_rd_en))
    else $error("read answer not one cycle after strobe");
  AST_CNT_UPPER: assert property (reg_rd_en && (reg_addr == OFS_SWCNT
    || reg_addr == OFS_HWCNT) |=> reg_rdata[31:8] == 24'h0)
    else $error("counter upper bits not zero");
  AST_BEATS: assert property (mem_cmd.req |-> mem_cmd.beats != 5'h00
    && mem_cmd.beats <= BEATS_16) else $error("burst length out of range");
  AST_REQ_HOLD: assert property (mem_cmd.req && !mem_gnt |=> mem_cmd.req
    && $stable(mem_cmd.addr)) else $error("request dropped before grant");
  AST_REQ_DROP: assert property (mem_cmd.req && mem_gnt |=> !mem_cmd.req)
    else $error("request held after grant");
  AST_IRQ_EN: assert property (!xfer_int_en |=> !thresh_irq)
    else $error("threshold pulse while disabled");
  AST_IRQ_PULSE: assert property (thresh_irq |=> !thresh_irq)
    else $error("threshold pulse too long");
  AST_DONE_PULSE: assert property (xfer_done |=> !xfer_done)
    else $error("end pulse too long");
  AST_PAUSE_QUIET: assert property (dma_paused [*2] |-> !mem_cmd.req
    && !ts_out.valid) else $error("traffic while paused");
  AST_TS_SRC: assert property (ts_out.valid && !stream_src_ext
    |-> $past(mem_rvalid)) else $error("stream word without memory beat");
endmodule // tslld_dma_ctrl_chk
bind tslld_dma_ctrl tslld_dma_ctrl_chk i_tslld_dma_ctrl_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .mem_cmd(mem_cmd), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
  .xfer_int_en(xfer_int_en), .stream_src_ext(stream_src_ext),
  .ts_out(ts_out), .thresh_irq(thresh_irq), .xfer_done(xfer_done),
  .dma_paused(dma_paused));
`default_nettype wire

/* File: tslld_tb.sv */
// self-checking bench for the descriptor dma channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb
  import tslld_pkg::*;
();
  logic                   clk_sys, rst_n, soft_clear, reg_wr_en, reg_rd_en;
  logic                   reg_rd_valid, mem_gnt, mem_rvalid, trig_pulse_in;
  logic                   src_ext;
  logic                   xfer_int_en, thresh_irq, xfer_done, dma_paused, slow;
  logic [11:0]            reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, mem_rdata, rd_val, last_ts;
  logic [NUM_FILTERS-1:0] fin;
  tslld_mem_cmd_t         mem_cmd;
  tslld_ts_word_t         ts_out, ext_ts;
  int                     bad_count, compares, ts_cnt, irq_cnt, done_cnt, cyc;
  tslld_dma_ctrl i_tslld_dma_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .soft_clear(soft_clear), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .mem_cmd(mem_cmd), .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .trig_pulse_in(trig_pulse_in), .xfer_int_en(xfer_int_en),
    .stream_src_ext(src_ext), .ext_ts(ext_ts), .ts_out(ts_out),
    .thresh_irq(thresh_irq), .xfer_done(xfer_done), .dma_paused(dma_paused),
    .filter_channel_finished(fin));
  tslld_mem_model i_tslld_mem_model (.clk_sys(clk_sys), .slow(slow),
    .mem_cmd(mem_cmd), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    ts_cnt <= ts_cnt + int'(ts_out.valid);
    irq_cnt <= irq_cnt + int'(thresh_irq);
    done_cnt <= done_cnt + int'(xfer_done);
    if (ts_out.valid)
      last_ts <= ts_out.data;
    // a hung handshake ends the run here
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, string nm);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    rd_val = reg_rdata;
    `CHK(nm, e, rd_val)
  endtask
  task automatic wait_done(input int n);
    repeat (3000)
      if (done_cnt == n)
        @(posedge clk_sys);
    `CHK("end pulse", n + 1, done_cnt)
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(OFS_CFG, 32'h0, "cfg");
    rd(OFS_HWCNT, 32'h0, "hwcnt");
    rd(OFS_DONE_HI, 32'h0, "done_hi");
    wr(OFS_BASE, 32'hffff_ffff);
    rd(OFS_BASE, 32'hffff_ffff, "base");
    wr(12'h0fc, 32'h1234_5678);
    rd(12'h0fc, 32'h0, "unmapped");
    wr(OFS_SWCNT, 32'hffff_ff5a);
    rd(OFS_SWCNT, 32'h5a, "swcnt");
    wr(OFS_HWCNT, 32'h33);
    rd(OFS_HWCNT, 32'h0, "hwcnt ro");
    wr(OFS_CFG, 32'hffff_fff4);
    rd(OFS_CFG, 32'h3f4, "cfg fields");
    wr(OFS_CFG, 32'h0);
    wr(OFS_SWCNT, 32'h0);
    wr(OFS_BASE, 32'h0);
    @(posedge clk_sys);
    fin <= 64'h8000_0001_8000_0004;
    @(posedge clk_sys);
    fin <= '0;
    rd(OFS_DONE_LO, 32'h8000_0004, "done_lo");
    rd(OFS_DONE_HI, 32'h8000_0001, "done_hi");
    wr(OFS_DONE_LO, 32'h0000_0004);
    rd(OFS_DONE_LO, 32'h8000_0000, "done_lo w1c");
    wr(OFS_DONE_HI, 32'hffff_ffff);
    rd(OFS_DONE_HI, 32'h0, "done_hi w1c");
    $display("test registers done");
  endtask
  // every threshold and burst code, 16 descriptors per run
  task automatic t_runs;
    logic [31:0] c;
    int          e, s0, i0, n;
    xfer_int_en <= 1'b1;
    for (int t = 0; t < 4; t++)
    begin
      c = 32'h8 | (t << 8) | (t << 6);
      e = 0;
      for (int k = 16 * t + 1; k <= 16 * t + 16; k++)
        e += int'((k & (63 >> t)) == 0);
      s0 = ts_cnt;
      i0 = irq_cnt;
      n = done_cnt;
      wr(OFS_SWCNT, 16 * (t + 1));
      wr(OFS_CFG, c);
      wr(OFS_CFG, c | 32'h1);
      rd(OFS_CFG, c, "start clears");
      wait_done(n);
      rd(OFS_CFG, c & 32'hfffffff7, "cfg done clear");
      rd(OFS_HWCNT, 16 * (t + 1), "hwcnt");
      `CHK("ts words", 80, ts_cnt - s0)
      `CHK("irq count", e, irq_cnt - i0)
    end
    $display("test runs done");
  endtask
  task automatic t_trigger;
    int n;
    n = done_cnt;
    wr(OFS_SWCNT, 32'd65);
    wr(OFS_CFG, 32'h79);
    repeat (20) @(posedge clk_sys);
    rd(OFS_HWCNT, 32'd64, "start ignored");
    @(posedge clk_sys);
    trig_pulse_in <= 1'b1;
    @(posedge clk_sys);
    trig_pulse_in <= 1'b0;
    wait_done(n);
    `CHK("fixed word", 32'ha5a5_1000, last_ts)
    rd(OFS_HWCNT, 32'd65, "wrapped slot");
    $display("test trigger done");
  endtask
  task automatic t_pause_stop;
    int n, s0;
    slow <= 1'b1;
    n = done_cnt;
    wr(OFS_SWCNT, 32'd70);
    wr(OFS_CFG, 32'h9);
    repeat (10) @(posedge clk_sys);
    wr(OFS_CFG, 32'hc);
    repeat (200)
      if (!dma_paused)
        @(posedge clk_sys);
    // let the last word of the halted burst reach the counter first
    #1;
    s0 = ts_cnt;
    repeat (20) @(posedge clk_sys);
    `CHK("paused", 1'b1, dma_paused)
    `CHK("paused words", s0, ts_cnt)
    rd(OFS_HWCNT, 32'd65, "paused count");
    wr(OFS_CFG, 32'h8);
    wait_done(n);
    rd(OFS_HWCNT, 32'd70, "resumed");
    slow <= 1'b0;
    n = done_cnt;
    s0 = ts_cnt;
    wr(OFS_SWCNT, 32'd90);
    wr(OFS_CFG, 32'h9);
    repeat (30) @(posedge clk_sys);
    wr(OFS_CFG, 32'ha);
    wait_done(n);
    `CHK("stopped early", 1'b1, (ts_cnt - s0) < 100)
    rd(OFS_CFG, 32'h0, "stop clears");
    @(posedge clk_sys);
    soft_clear <= 1'b1;
    @(posedge clk_sys);
    soft_clear <= 1'b0;
    rd(OFS_HWCNT, 32'h0, "soft clear");
    $display("test pause and stop done");
  endtask
  // external stream passes through, dma words are dropped
  task automatic t_ext;
    int n, s0;
    n = done_cnt;
    s0 = ts_cnt;
    src_ext <= 1'b1;
    wr(OFS_SWCNT, 32'h1);
    wr(OFS_CFG, 32'h9);
    wait_done(n);
    @(posedge clk_sys);
    ext_ts <= '{valid: 1'b1, data: 32'h5eed_0001};
    @(posedge clk_sys);
    ext_ts <= '0;
    repeat (3) @(posedge clk_sys);
    `CHK("ext words", s0 + 1, ts_cnt)
    `CHK("ext word", 32'h5eed_0001, last_ts)
    src_ext <= 1'b0;
    $display("test external source done");
  endtask
  initial
  begin
    {rst_n, soft_clear, reg_wr_en, reg_rd_en, trig_pulse_in} = '0;
    {xfer_int_en, slow, src_ext, ext_ts, reg_addr, reg_wdata, fin} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs;
    t_runs;
    t_trigger;
    t_pause_stop;
    t_ext;
    conclude;
  end
endmodule // tb
`default_nettype wire
